/* File: inc/wdr_pkg.sv */
// package: constants and types of the watchdog with reset-cause recording
// Function
// - watchdog comes up enabled after any reset
// - key 0x55 then 0xAA restarts timeout
// - cause register read-only; writes only service
// - timeout while enabled forces system reset
// - any other key byte resets at once
// - clock select, three timeouts per clock
// - defaults: slow clock, longest timeout
// - windowed: service only in final quarter
// - early service in window mode resets
// - no window when slow clock selected
// - counter init on reset, first option writes
// - timeout field zero disables watchdog
// - bus clock: counter holds in debug/stop
// - slow clock: counter zeroed in debug/stop
// - eight reset sources, seven with flags
package wdr_pkg;
   // register byte offsets
   localparam logic [7:0] OFF_CAUSE = 8'h00;
   localparam logic [7:0] OFF_OPT1 = 8'h04;
   localparam logic [7:0] OFF_OPT2 = 8'h08;
   localparam logic [7:0] OFF_STAT = 8'h0C;
   localparam logic [7:0] OFF_MASK = 8'h10;
   localparam logic [7:0] OFF_COUNT = 8'h14;
   // field positions
   localparam int OPT1_TMO_LSB = 0;
   localparam int OPT2_CLK_BIT = 0;
   localparam int OPT2_WIN_BIT = 1;
   localparam int LOCK_BIT = 7;
   // reset values
   localparam logic [1:0] TMO_RST = 2'h3;
   localparam logic CLK_RST = 1'b0;
   localparam logic WIN_RST = 1'b0;
   // service keys and bus size
   localparam logic [7:0] KEY_FIRST = 8'h55;
   localparam logic [7:0] KEY_SECOND = 8'hAA;
   localparam logic [2:0] SIZE_WORD = 3'h2;
   // counter and timeout lengths in counted cycles
   localparam int CNT_W = 11;
   localparam logic [CNT_W-1:0] TMO_SHORT = 11'h020;
   localparam logic [CNT_W-1:0] TMO_MID = 11'h100;
   localparam logic [CNT_W-1:0] TMO_LONG = 11'h400;
   // reset sources: cause bits 0 power-on .. 6 clock loss
   localparam int NSRC = 7;
   localparam int EXT_W = 6;
   localparam logic [NSRC-1:0] CAUSE_RST = 7'h01;
   localparam int EV_W = 3;
   localparam int SYNC_W = 9;
   typedef enum logic [0:0] {
      KEY_IDLE = 1'b0,
      KEY_ARMED = 1'b1
   } wdr_key_t;
endpackage : wdr_pkg

/* File: inc/wdr_if.sv */
// interface: top control to watchdog counter
`timescale 1ns/1ps
interface wdr_if;
   import wdr_pkg::*;
   logic clear;
   logic step;
   logic [CNT_W-1:0] limit;
   logic [CNT_W-1:0] count;
   logic expire;
   logic winOpen;
   modport ctl(output clear, step, limit, input count, expire, winOpen);
   modport cnt(input clear, step, limit, output count, expire, winOpen);
endinterface : wdr_if

/* File: src/wdr_counter.sv */
// watchdog counter with expiry pulse and window flag
`timescale 1ns/1ps
module wdr_counter (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // control
   wdr_if.cnt cnt
);
   import wdr_pkg::*;

   typedef struct packed {
      logic [CNT_W-1:0] count;
      logic expire;
   } wdr_cnt_t;

   wdr_cnt_t s_r;
   wdr_cnt_t s_nxt;

   ////////////////////////////////////////////////////////////////
   always_comb begin
      s_nxt = s_r;
      s_nxt.expire = 1'b0;
      if (cnt.clear) begin
         s_nxt.count = '0;
      end else if (cnt.step) begin
         if (s_r.count >= cnt.limit - 1'b1) begin
            s_nxt.count = '0;
            s_nxt.expire = 1'b1;
         end else begin
            s_nxt.count = s_r.count + 1'b1;
         end
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign cnt.count = s_r.count;
   assign cnt.expire = s_r.expire;
   // final quarter of the period
   assign cnt.winOpen = s_r.count >= cnt.limit - (cnt.limit >> 2);
endmodule : wdr_counter

/* File: src/wdr_cause.sv */
// reset-cause register and system reset pulse
`timescale 1ns/1ps
module wdr_cause (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // requests: bit 0 debug forced, bits 1..6 flagged sources
   input wire logic [wdr_pkg::NSRC-1:0] req,
   // results
   output logic [wdr_pkg::NSRC-1:0] cause,
   output logic sysReset
);
   import wdr_pkg::*;

   typedef struct packed {
      logic [NSRC-1:0] cause;
      logic pulse;
   } wdr_cause_t;

   wdr_cause_t s_r;
   wdr_cause_t s_nxt;

   ////////////////////////////////////////////////////////////////
   always_comb begin
      logic found;
      found = 1'b0;
      s_nxt = s_r;
      s_nxt.pulse = 1'b0;
      if (|req) begin
         s_nxt.pulse = 1'b1;
         s_nxt.cause = '0;
         // lowest index wins; debug forced alone leaves all clear
         for (int i = 1; i < NSRC; i++) begin
            if (req[i] && !found) begin
               s_nxt.cause[i] = 1'b1;
               found = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s_r <= '{cause: CAUSE_RST, pulse: 1'b0};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign cause = s_r.cause;
   assign sysReset = s_r.pulse;
endmodule : wdr_cause

/* File: src/wdr_top.sv */
// watchdog with reset-cause recording, AHB-Lite register slave
`timescale 1ns/1ps
module wdr_top #(
   parameter logic [wdr_pkg::CNT_W-1:0] BUS_SHORT = wdr_pkg::TMO_SHORT,
   parameter logic [wdr_pkg::CNT_W-1:0] BUS_MID = wdr_pkg::TMO_MID,
   parameter logic [wdr_pkg::CNT_W-1:0] BUS_LONG = wdr_pkg::TMO_LONG,
   parameter logic [wdr_pkg::CNT_W-1:0] SLOW_SHORT = wdr_pkg::TMO_SHORT,
   parameter logic [wdr_pkg::CNT_W-1:0] SLOW_MID = wdr_pkg::TMO_MID,
   parameter logic [wdr_pkg::CNT_W-1:0] SLOW_LONG = wdr_pkg::TMO_LONG
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // system pins
   input wire logic lowPowerClk,
   input wire logic debugMode,
   input wire logic stopMode,
   input wire logic [wdr_pkg::EXT_W-1:0] resetReqExt,
   output logic systemReset,
   output logic [wdr_pkg::NSRC-1:0] resetCause,
   output logic irq
);
   import wdr_pkg::*;

   typedef struct packed {
      logic [SYNC_W-1:0] syncA;
      logic [SYNC_W-1:0] syncB;
      logic [SYNC_W-1:0] syncC;
      logic wrPend;
      logic [5:0] wrIdx;
      logic [31:0] rdData;
      logic [1:0] tmoSel;
      logic busClk;
      logic winEn;
      logic lock1;
      logic lock2;
      wdr_key_t key;
      logic prevWin;
      logic [EV_W-1:0] stat;
      logic [EV_W-1:0] mask;
      logic irq;
      logic wdogReq;
   } wdr_top_t;

   localparam wdr_top_t ST_RST = '{
      tmoSel: TMO_RST,
      busClk: CLK_RST,
      winEn: WIN_RST,
      key: KEY_IDLE,
      default: '0
   };

   wdr_top_t s_r;
   wdr_top_t s_nxt;
   wdr_if cif();
   logic [NSRC-1:0] srcReq;
   logic [EXT_W-1:0] extRise;
   logic lpTick;
   logic quiet;
   logic windowed;
   logic serviceNow;
   logic initNow;
   logic [EV_W-1:0] events;

   ////////////////////////////////////////////////////////////////
   // counter and cause units
   wdr_counter u_counter (
      .clk(clk),
      .reset(reset),
      .cnt(cif.cnt)
   );

   wdr_cause u_cause (
      .clk(clk),
      .reset(reset),
      .req(srcReq),
      .cause(resetCause),
      .sysReset(systemReset)
   );

   ////////////////////////////////////////////////////////////////
   // timeout lookup per clock source
   function automatic logic [CNT_W-1:0] limitOf(input logic bus, input logic [1:0] sel);
      case (sel)
         2'h1: limitOf = bus ? BUS_SHORT : SLOW_SHORT;
         2'h2: limitOf = bus ? BUS_MID : SLOW_MID;
         2'h3: limitOf = bus ? BUS_LONG : SLOW_LONG;
         default: limitOf = '0;
      endcase
   endfunction : limitOf

   ////////////////////////////////////////////////////////////////
   // synchronised pins, second and third stages only
   assign extRise = s_r.syncB[EXT_W-1:0] & ~s_r.syncC[EXT_W-1:0];
   assign lpTick = s_r.syncB[8] & ~s_r.syncC[8];
   assign quiet = s_r.syncB[6] | s_r.syncB[7];

   // debug forced, pin, watchdog, then remaining external sources
   assign srcReq = {extRise[5:2], s_r.wdogReq, extRise[1:0]};

   assign windowed = s_r.busClk & s_r.winEn & (s_r.tmoSel != 2'h0);

   assign cif.limit = limitOf(s_r.busClk, s_r.tmoSel);
   // slow clock restarts from zero after debug or stop
   assign cif.clear = systemReset | serviceNow | initNow | (!s_r.busClk & quiet);
   // disabled when timeout field is zero; bus clock just holds
   assign cif.step = (s_r.tmoSel != 2'h0) & !quiet & (s_r.busClk | lpTick);

   ////////////////////////////////////////////////////////////////
   always_comb begin
      logic [7:0] keyByte;
      logic [EV_W-1:0] clr;
      logic rdAct;
      keyByte = hwdata[7:0];
      clr = '0;
      rdAct = hsel & hready & htrans[1] & !hwrite;
      serviceNow = 1'b0;
      initNow = 1'b0;
      s_nxt = s_r;
      s_nxt.wdogReq = cif.expire;

      // data phase of a captured write
      if (s_r.wrPend) begin
         case (s_r.wrIdx)
            OFF_CAUSE[7:2]: begin
               // writes never touch the stored cause
               if (keyByte != KEY_FIRST && keyByte != KEY_SECOND) begin
                  s_nxt.wdogReq = 1'b1;
               end else if (windowed && !cif.winOpen) begin
                  s_nxt.wdogReq = 1'b1;
               end else if (keyByte == KEY_FIRST) begin
                  s_nxt.key = KEY_ARMED;
               end else if (s_r.key == KEY_ARMED) begin
                  serviceNow = 1'b1;
                  s_nxt.key = KEY_IDLE;
               end
            end
            OFF_OPT1[7:2]: begin
               if (!s_r.lock1) begin
                  s_nxt.tmoSel = hwdata[OPT1_TMO_LSB +: 2];
                  s_nxt.lock1 = 1'b1;
                  initNow = 1'b1;
               end
            end
            OFF_OPT2[7:2]: begin
               if (!s_r.lock2) begin
                  s_nxt.busClk = hwdata[OPT2_CLK_BIT];
                  s_nxt.winEn = hwdata[OPT2_WIN_BIT];
                  s_nxt.lock2 = 1'b1;
                  initNow = 1'b1;
               end
            end
            OFF_STAT[7:2]: begin
               clr = hwdata[EV_W-1:0];
            end
            OFF_MASK[7:2]: begin
               s_nxt.mask = hwdata[EV_W-1:0];
            end
            default: begin
            end
         endcase
      end

      // events: service done, window opened, option register locked
      events = {initNow, windowed & cif.winOpen & !s_r.prevWin, serviceNow};
      s_nxt.prevWin = cif.winOpen;
      // a new event beats a simultaneous clear
      s_nxt.stat = (s_r.stat & ~clr) | events;
      s_nxt.irq = |(s_nxt.stat & s_nxt.mask);

      // address phase capture; only whole-word writes act
      s_nxt.wrPend = hsel & hready & htrans[1] & hwrite & (hsize == SIZE_WORD);
      s_nxt.wrIdx = haddr[7:2];
      if (rdAct) begin
         s_nxt.rdData = '0;
         if (haddr[31:8] == 24'h00_0000) begin
            case (haddr[7:2])
               OFF_CAUSE[7:2]: s_nxt.rdData[NSRC-1:0] = resetCause;
               OFF_OPT1[7:2]: begin
                  s_nxt.rdData[OPT1_TMO_LSB +: 2] = s_r.tmoSel;
                  s_nxt.rdData[LOCK_BIT] = s_r.lock1;
               end
               OFF_OPT2[7:2]: begin
                  s_nxt.rdData[OPT2_CLK_BIT] = s_r.busClk;
                  s_nxt.rdData[OPT2_WIN_BIT] = s_r.winEn;
                  s_nxt.rdData[LOCK_BIT] = s_r.lock2;
               end
               OFF_STAT[7:2]: s_nxt.rdData[EV_W-1:0] = s_r.stat;
               OFF_MASK[7:2]: s_nxt.rdData[EV_W-1:0] = s_r.mask;
               OFF_COUNT[7:2]: s_nxt.rdData[CNT_W-1:0] = cif.count;
               default: s_nxt.rdData = '0;
            endcase
         end
      end

      // any recorded reset returns the control state to defaults
      if (systemReset) begin
         s_nxt = ST_RST;
      end
      s_nxt.syncA = {lowPowerClk, stopMode, debugMode, resetReqExt};
      s_nxt.syncB = s_r.syncA;
      s_nxt.syncC = s_r.syncB;
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s_r <= ST_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////
   // zero wait states, always OKAY
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = s_r.rdData;
   assign irq = s_r.irq;
endmodule : wdr_top

/* File: sim/wdr_checker.sv */
// checker: port-level properties of the watchdog block
`timescale 1ns/1ps
module wdr_checker (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // bus
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   // system pins
   input wire logic lowPowerClk,
   input wire logic debugMode,
   input wire logic stopMode,
   input wire logic [wdr_pkg::EXT_W-1:0] resetReqExt,
   input wire logic systemReset,
   input wire logic [wdr_pkg::NSRC-1:0] resetCause,
   input wire logic irq
);
   import wdr_pkg::*;
   ////////////////////////////////////////////////////////////////////////////
   logic wrCause_r;
   logic rdCause_r;
   logic take;
   assign take = hsel && hready && htrans[1] && haddr[7:0] == OFF_CAUSE;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wrCause_r <= 1'b0;
         rdCause_r <= 1'b0;
      end else begin
         wrCause_r <= take && hwrite && hsize == SIZE_WORD;
         rdCause_r <= take && !hwrite;
      end
   end
   default clocking dc @(posedge clk); endclocking
   default disable iff (reset);
   ////////////////////////////////////////////////////////////////////////////
   okay_resp_a: assert property (hreadyout && !hresp)
      else $error("bus answer not zero-wait okay");
   pulse_single_a: assert property (systemReset |=> !systemReset)
      else $error("system reset pulse too long");
   cause_stable_a: assert property ($changed(resetCause) |-> systemReset)
      else $error("cause changed without reset");
   cause_onehot_a: assert property (systemReset |-> $onehot0(resetCause))
      else $error("more than one cause flag");
   bad_key_a: assert property (wrCause_r && hwdata[7:0] != KEY_FIRST
      && hwdata[7:0] != KEY_SECOND |-> ##2 systemReset && resetCause == 7'h04)
      else $error("bad key did not reset");
   cause_read_a: assert property (rdCause_r && !systemReset
      |-> hrdata[6:0] == resetCause)
      else $error("cause read mismatch");
   pin_reset_a: assert property (|(resetReqExt & ~$past(resetReqExt))
      |-> ##[2:8] systemReset)
      else $error("pin request without reset");
   pin_cause_a: assert property ($rose(resetReqExt[2])
      |-> ##[2:8] systemReset && resetCause == 7'h08)
      else $error("opcode cause not flagged");
endmodule : wdr_checker

bind wdr_top wdr_checker chk (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
   .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .lowPowerClk(lowPowerClk),
   .debugMode(debugMode), .stopMode(stopMode), .resetReqExt(resetReqExt),
   .systemReset(systemReset), .resetCause(resetCause), .irq(irq));

/* File: sim/wdr_test.sv */
// testbench: bus-driven scenarios for the watchdog block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin nCompared++; if ((got) !== (ex)) begin errCount++; \
   $display("ERROR %s exp %h got %h", nm, ex, got); end end
module wdr_test;
   import wdr_pkg::*;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [31:0] haddr = '0;
   logic [1:0] htrans = '0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = '0;
   logic hsel = 1'b0;
   logic [2:0] hsize = SIZE_WORD;
   logic [2:0] wsize = SIZE_WORD;
   logic debugMode = 1'b0;
   logic stopMode = 1'b0;
   logic lowPowerClk = 1'b0;
   logic lpRun = 1'b0;
   logic [2:0] lpDiv = '0;
   logic [EXT_W-1:0] resetReqExt = '0;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic systemReset;
   logic [NSRC-1:0] resetCause;
   logic irq;
   logic rdPend = 1'b0;
   logic [31:0] expD;
   logic [NSRC-1:0] expC;
   logic [31:0] rdQ[$];
   logic [NSRC-1:0] rstQ[$];
   logic [7:0] b;
   int errCount = 0;
   int nCompared = 0;
   int cycles = 0;
   int seed = 28573;
   // short slow-clock timeouts keep the run brief; bus short timeout doubled to 0x40
   wdr_top #(.BUS_SHORT(11'h040), .SLOW_SHORT(11'h008), .SLOW_MID(11'h010),
      .SLOW_LONG(11'h020)) uut (
      .clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .lowPowerClk(lowPowerClk),
      .debugMode(debugMode), .stopMode(stopMode), .resetReqExt(resetReqExt),
      .systemReset(systemReset), .resetCause(resetCause), .irq(irq));
   initial forever #4 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////////
   // slow tick gated so the default watchdog only runs when asked
   always @(posedge clk) begin
      lpDiv <= lpDiv + 3'h1;
      lowPowerClk <= lpRun && lpDiv[2];
   end
   always @(posedge clk) begin
      rdPend <= hsel && htrans[1] && !hwrite;
      if (rdPend) begin
         expD = (rdQ.size() != 0) ? rdQ.pop_front() : 'x;
         `CHK("hrdata", expD, hrdata)
         `CHK("hresp", 1'b0, hresp)
      end
      // an unannounced reset pops nothing and fails
      if (systemReset === 1'b1) begin
         expC = (rstQ.size() != 0) ? rstQ.pop_front() : 'x;
         `CHK("resetCause", expC, resetCause)
      end
      cycles++;
      if (cycles == 30000) begin
         errCount++;
         giveVerdict();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   task tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
      haddr <= {24'h0000_00, a};
      hwrite <= w;
      hsel <= 1'b1;
      hsize <= wsize;
      htrans <= 2'h2;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      if (!w) rdQ.push_back(e);
      do @(posedge clk); while (hreadyout !== 1'b1);
   endtask : bus
   task wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, '0);
   endtask : wr
   task rd(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, '0, e);
   endtask : rd
   task waitRst;
      repeat (2000) if (rstQ.size() != 0) @(posedge clk);
      `CHK("pending resets", 0, rstQ.size())
      tick(4);
   endtask : waitRst
   task chkIrq(input logic e);
      tick(2);
      #1;
      `CHK("irq", e, irq)
      @(posedge clk);
   endtask : chkIrq
   task giveVerdict;
      $display("compared %0d, mismatches %0d", nCompared, errCount);
      if (errCount == 0 && nCompared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : giveVerdict
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      tick(3);
      reset <= 1'b0;
      tick(1);
      rd(OFF_CAUSE, 32'h0000_0001);
      rd(OFF_OPT1, 32'h0000_0003);
      rd(OFF_OPT2, 32'h0000_0000);
      rd(8'h18, 32'h0000_0000);
      // a byte-sized bad key must be ignored, not reset
      wsize = 3'h0;
      wr(OFF_CAUSE, 32'h0000_0011);
      wsize = SIZE_WORD;
      wr(OFF_CAUSE, 32'h0000_00AA);
      wr(OFF_CAUSE, 32'h0000_0055);
      wr(OFF_CAUSE, 32'h0000_00AA);
      rd(OFF_CAUSE, 32'h0000_0001);
      rd(OFF_STAT, 32'h0000_0001);
      chkIrq(1'b0);
      wr(OFF_MASK, 32'h0000_0001);
      chkIrq(1'b1);
      wr(OFF_STAT, 32'h0000_0001);
      chkIrq(1'b0);
      for (int i = 0; i < 2; i++) begin
         do b = 8'($random(seed)); while (b == KEY_FIRST || b == KEY_SECOND);
         rstQ.push_back(7'h04);
         wr(OFF_CAUSE, {24'h0000_00, b});
         waitRst();
      end
      rd(OFF_CAUSE, 32'h0000_0004);
      lpRun <= 1'b1;
      tick(100);
      stopMode <= 1'b1;
      tick(8);
      rd(OFF_COUNT, 32'h0000_0000);
      rstQ.push_back(7'h04);
      stopMode <= 1'b0;
      waitRst();
      lpRun <= 1'b0;
      wr(OFF_OPT1, 32'h0000_0001);
      wr(OFF_OPT2, 32'h0000_0003);
      wr(OFF_OPT1, 32'h0000_0000);
      rd(OFF_OPT1, 32'h0000_0081);
      rd(OFF_OPT2, 32'h0000_0083);
      rstQ.push_back(7'h04);
      wr(OFF_CAUSE, 32'h0000_0055);
      waitRst();
      rd(OFF_OPT2, 32'h0000_0000);
      wr(OFF_OPT1, 32'h0000_0001);
      wr(OFF_OPT2, 32'h0000_0003);
      tick(50);
      // debug freezes the bus-clock count at 52
      debugMode <= 1'b1;
      tick(4);
      rd(OFF_COUNT, 32'h0000_0034);
      wr(OFF_CAUSE, 32'h0000_0055);
      wr(OFF_CAUSE, 32'h0000_00AA);
      debugMode <= 1'b0;
      rstQ.push_back(7'h04);
      waitRst();
      wr(OFF_OPT1, 32'h0000_0001);
      wr(OFF_OPT2, 32'h0000_0002);
      wr(OFF_CAUSE, 32'h0000_0055);
      wr(OFF_CAUSE, 32'h0000_00AA);
      rd(OFF_STAT, 32'h0000_0005);
      for (int k = 0; k < EXT_W; k++) begin
         rstQ.push_back(k == 0 ? 7'h00 : k == 1 ? 7'h02 : 7'(1 << (k + 1)));
         resetReqExt <= 6'(1 << k);
         tick(4);
         resetReqExt <= '0;
         waitRst();
      end
      wr(OFF_OPT1, 32'h0000_0000);
      rd(OFF_OPT1, 32'h0000_0080);
      lpRun <= 1'b1;
      tick(600);
      lpRun <= 1'b0;
      reset <= 1'b1;
      tick(2);
      reset <= 1'b0;
      tick(1);
      rd(OFF_CAUSE, 32'h0000_0001);
      tick(2);
      giveVerdict();
   end
endmodule : wdr_test
